// [design/pnd_pkg.sv]
// constants, field layout and carrier types of the pattern next-data register bank
// assumes one apb clock domain; compare-match pulses arrive on that same clock
// Operation
// [RULE_01] port b direction: 8-bit write-only, one bit per pin, resets to zero
// [RULE_02] software sets direction bit to 1 on every pin used for pattern output
// [RULE_03] port b data: 8 bits, resets zero, holds levels of groups 2 and 3
// [RULE_04] port b data bits enabled for pattern output ignore processor writes
// [RULE_05] low-pair next data holds 8 bits, copied to port a on selected match
// [RULE_06] low-pair next data clears on reset and hardware standby, kept otherwise
// [RULE_07] high-pair next data clears on reset and hardware standby, kept otherwise
// [RULE_08] shared trigger groups 0/1: all eight bits at first address, group 1 upper
// [RULE_09] shared trigger groups 0/1: alternate address ignores writes, reads all ones
// [RULE_10] separate triggers: group 1 upper nibble first address, group 0 low nibble alt
// [RULE_11] separate triggers 0/1: unused nibbles of both addresses read one, unwritable
// [RULE_12] high-pair next data holds 8 bits, copied to port b on selected match
// [RULE_13] shared trigger groups 2/3: all eight bits at first address, group 3 upper
// [RULE_14] shared trigger groups 2/3: alternate address ignores writes, reads all ones
// [RULE_15] separate triggers: group 3 upper nibble first address, group 2 low nibble alt
// [RULE_16] separate triggers 2/3: unused nibbles of both addresses read one, unwritable
// [RULE_17] a next-data bit is copied only when its enable bit is one
// [RULE_18] trigger field 00 ch0, 01 ch1, 1x ch2; select register resets to ones
// [RULE_19] port a data bits enabled for pattern output ignore processor writes
// [RULE_20] shared or separate map follows trigger fields, re-decided on every write
// [RULE_21] transfer in the match cycle, only that group's four enabled bits

package pnd_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 22;
  localparam int IDX_W = 20;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [19:0] IDX_PORT_B_DIR = 20'hee00a;
  localparam logic [19:0] IDX_PORT_A_DATA = 20'hfffd9;
  localparam logic [19:0] IDX_PORT_B_DATA = 20'hfffda;
  localparam logic [19:0] IDX_TRIG_SEL = 20'hfffa1;
  localparam logic [19:0] IDX_ENA_HI = 20'hfffa2;
  localparam logic [19:0] IDX_ENA_LO = 20'hfffa3;
  localparam logic [19:0] IDX_ND_HI = 20'hfffa4;
  localparam logic [19:0] IDX_ND_LO = 20'hfffa5;
  localparam logic [19:0] IDX_ND_G2_ALT = 20'hfffa6;
  localparam logic [19:0] IDX_ND_G0_ALT = 20'hfffa7;

  // ****************************************************************
  // reset and reserved values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_TRIG = 8'hff;
  localparam logic [7:0] RSV_BYTE = 8'hff;
  localparam logic [3:0] RSV_NIBBLE = 4'hf;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // ****************************************************************
  // trigger select field layout and channel codes
  // ****************************************************************
  localparam int TRIG_FIELD_W = 2;
  localparam int GROUP_W = 4;
  localparam int N_GROUPS = 4;
  localparam logic [1:0] CH0 = 2'h0;
  localparam logic [1:0] CH1 = 2'h1;
  localparam logic [1:0] CH2 = 2'h2;

  // answer of one next-data address: what it reads and which bits it may write
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] wmask;
  } pnd_map_s;

endpackage : pnd_pkg

// [design/pnd_trig_sel.sv]
// trigger decode for one output group
// assumes match pulses are on the same clock as the caller
`timescale 1ns/1ps

module pnd_trig_sel (
  input wire logic [1:0] sel,
  input wire logic [2:0] match,
  output logic [1:0] chan,
  output logic fire
);

  always_comb
  begin
    if (sel == pnd_pkg::CH0)
    begin
      chan = pnd_pkg::CH0; // see [RULE_18]
      fire = match[0];
    end
    else if (sel == pnd_pkg::CH1)
    begin
      chan = pnd_pkg::CH1; // see [RULE_18]
      fire = match[1];
    end
    else
    begin
      chan = pnd_pkg::CH2; // see [RULE_18]
      fire = match[2];
    end
  end

endmodule : pnd_trig_sel

// [design/pnd_pair_map.sv]
// read view and write mask of one next-data address of a group pair
// assumes the caller decides sharing and which of the two addresses is hit
`timescale 1ns/1ps

module pnd_pair_map (
  input wire logic shared,
  input wire logic alt,
  input wire logic [7:0] nd,
  output pnd_pkg::pnd_map_s map
);

  always_comb
  begin
    if (shared && !alt)
    begin
      map.rdata = nd; // see [RULE_08] see [RULE_13]
      map.wmask = 8'hff;
    end
    else if (shared)
    begin
      map.rdata = pnd_pkg::RSV_BYTE; // see [RULE_09] see [RULE_14]
      map.wmask = 8'h00;
    end
    else if (!alt)
    begin
      map.rdata = {nd[7:4], pnd_pkg::RSV_NIBBLE}; // see [RULE_10] see [RULE_11]
      map.wmask = 8'hf0;
    end
    else
    begin
      map.rdata = {pnd_pkg::RSV_NIBBLE, nd[3:0]}; // see [RULE_15] see [RULE_16]
      map.wmask = 8'h0f;
    end
  end

endmodule : pnd_pair_map

// [design/pnd_regs.sv]
// pattern next-data register bank: apb slave, next-data, enables, trigger
// select, port data and port b direction, with compare-match transfer
// assumes compare-match pulses come from logic on pclk, one cycle each;
// hw_standby is an asynchronous pin and is synchronised here
`timescale 1ns/1ps

module pnd_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic hw_standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [21:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] compare_match,
  output logic [7:0] port_a_output_data,
  output logic [7:0] port_b_output_data,
  output logic [7:0] port_b_direction
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] next_data_lo_pair_ff;
  logic [7:0] next_data_hi_pair_ff;
  logic [7:0] output_enable_lo_pair_ff;
  logic [7:0] output_enable_hi_pair_ff;
  logic [7:0] trigger_select_reg_ff;
  logic [7:0] port_a_data_ff;
  logic [7:0] port_b_data_ff;
  logic [7:0] port_b_dir_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic stby_meta_ff;
  logic stby_sync_ff;

  logic [19:0] idx;
  logic aligned;
  logic access;
  logic wr_done;
  logic [7:0] wbyte;
  logic [7:0] nxt_rbyte;
  logic nxt_err;
  logic [15:0] xfer;
  logic [1:0] chan [pnd_pkg::N_GROUPS];
  logic fire [pnd_pkg::N_GROUPS];
  logic shared [2];
  pnd_pkg::pnd_map_s map [4];
  logic [7:0] nxt_port_a;
  logic [7:0] nxt_port_b;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign port_a_output_data = port_a_data_ff;
  assign port_b_output_data = port_b_data_ff;
  assign port_b_direction = port_b_dir_ff;

  // ****************************************************************
  // hardware standby synchroniser
  // ****************************************************************
  // standby clears next data, enables and trigger select, only through the synchronised level,
  // so a glitch on the pin cannot tear a half-updated register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stby_meta_ff <= 1'b0;
      stby_sync_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      stby_meta_ff <= hw_standby;
      stby_sync_ff <= stby_meta_ff;
    end
  end

  // ****************************************************************
  // trigger decode and transfer masks, one pass per group
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < pnd_pkg::N_GROUPS; g++)
    begin : gen_group
      pnd_trig_sel u_trig (
        .sel(trigger_select_reg_ff[g*pnd_pkg::TRIG_FIELD_W +: pnd_pkg::TRIG_FIELD_W]),
        .match(compare_match),
        .chan(chan[g]),
        .fire(fire[g])
      );
      // only the firing group's enabled bits move
      assign xfer[g*pnd_pkg::GROUP_W +: pnd_pkg::GROUP_W] =
        {pnd_pkg::GROUP_W{fire[g]}} &
        (g < 2 ? output_enable_lo_pair_ff[(g%2)*pnd_pkg::GROUP_W +: pnd_pkg::GROUP_W]
               : output_enable_hi_pair_ff[(g%2)*pnd_pkg::GROUP_W +: pnd_pkg::GROUP_W]);
        // see [RULE_17] see [RULE_21]
    end
  endgenerate

  // ****************************************************************
  // shared or separate address map per pair
  // ****************************************************************
  // compares decoded channels, so codes 10 and 11 count as one trigger
  assign shared[0] = (chan[0] == chan[1]); // see [RULE_20]
  assign shared[1] = (chan[2] == chan[3]); // see [RULE_20]

  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : gen_map
      pnd_pair_map u_map (
        .shared(shared[k/2]),
        .alt(k % 2 == 1),
        .nd(k < 2 ? next_data_lo_pair_ff : next_data_hi_pair_ff),
        .map(map[k])
      );
    end
  endgenerate

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign idx = paddr[21:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign access = psel && penable;
  assign wr_done = access && pready_ff && pwrite;
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    nxt_rbyte = pnd_pkg::RST_BYTE;
    nxt_err = 1'b0;
    if (!aligned)
    begin
      nxt_err = 1'b1;
    end
    else if (idx == pnd_pkg::IDX_ND_LO)
    begin
      nxt_rbyte = map[0].rdata;
    end
    else if (idx == pnd_pkg::IDX_ND_G0_ALT)
    begin
      nxt_rbyte = map[1].rdata;
    end
    else if (idx == pnd_pkg::IDX_ND_HI)
    begin
      nxt_rbyte = map[2].rdata;
    end
    else if (idx == pnd_pkg::IDX_ND_G2_ALT)
    begin
      nxt_rbyte = map[3].rdata;
    end
    else if (idx == pnd_pkg::IDX_ENA_LO)
    begin
      nxt_rbyte = output_enable_lo_pair_ff;
    end
    else if (idx == pnd_pkg::IDX_ENA_HI)
    begin
      nxt_rbyte = output_enable_hi_pair_ff;
    end
    else if (idx == pnd_pkg::IDX_TRIG_SEL)
    begin
      nxt_rbyte = trigger_select_reg_ff;
    end
    else if (idx == pnd_pkg::IDX_PORT_A_DATA)
    begin
      nxt_rbyte = port_a_data_ff;
    end
    else if (idx == pnd_pkg::IDX_PORT_B_DATA)
    begin
      nxt_rbyte = port_b_data_ff;
    end
    else if (idx == pnd_pkg::IDX_PORT_B_DIR)
    begin
      nxt_rbyte = pnd_pkg::RST_BYTE; // see [RULE_01]
    end
    else
    begin
      nxt_err = 1'b1;
    end
  end

  // ****************************************************************
  // apb answer: one wait state, then pready for one cycle
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (access && !pready_ff)
      begin
        pready_ff <= 1'b1;
        prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, nxt_rbyte};
        pslverr_ff <= nxt_err;
      end
      else
      begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // next-data registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_data_lo_pair_ff <= pnd_pkg::RST_BYTE;
    end
    else if (clk_en)
    begin
      if (stby_sync_ff)
      begin
        next_data_lo_pair_ff <= pnd_pkg::RST_BYTE; // see [RULE_06]
      end
      else if (wr_done && aligned && idx == pnd_pkg::IDX_ND_LO)
      begin
        next_data_lo_pair_ff <= (next_data_lo_pair_ff & ~map[0].wmask) |
                                (wbyte & map[0].wmask); // see [RULE_08] see [RULE_10]
      end
      else if (wr_done && aligned && idx == pnd_pkg::IDX_ND_G0_ALT)
      begin
        next_data_lo_pair_ff <= (next_data_lo_pair_ff & ~map[1].wmask) |
                                (wbyte & map[1].wmask); // see [RULE_09] see [RULE_11]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      next_data_hi_pair_ff <= pnd_pkg::RST_BYTE;
    end
    else if (clk_en)
    begin
      if (stby_sync_ff)
      begin
        next_data_hi_pair_ff <= pnd_pkg::RST_BYTE; // see [RULE_07]
      end
      else if (wr_done && aligned && idx == pnd_pkg::IDX_ND_HI)
      begin
        next_data_hi_pair_ff <= (next_data_hi_pair_ff & ~map[2].wmask) |
                                (wbyte & map[2].wmask); // see [RULE_13] see [RULE_15]
      end
      else if (wr_done && aligned && idx == pnd_pkg::IDX_ND_G2_ALT)
      begin
        next_data_hi_pair_ff <= (next_data_hi_pair_ff & ~map[3].wmask) |
                                (wbyte & map[3].wmask); // see [RULE_14] see [RULE_16]
      end
    end
  end

  // ****************************************************************
  // enables, trigger select, port b direction
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_enable_lo_pair_ff <= pnd_pkg::RST_BYTE;
      output_enable_hi_pair_ff <= pnd_pkg::RST_BYTE;
      trigger_select_reg_ff <= pnd_pkg::RST_TRIG; // see [RULE_18]
    end
    else if (clk_en)
    begin
      if (stby_sync_ff)
      begin
        output_enable_lo_pair_ff <= pnd_pkg::RST_BYTE;
        output_enable_hi_pair_ff <= pnd_pkg::RST_BYTE;
        trigger_select_reg_ff <= pnd_pkg::RST_TRIG;
      end
      else if (wr_done && aligned && idx == pnd_pkg::IDX_ENA_LO)
      begin
        output_enable_lo_pair_ff <= wbyte;
      end
      else if (wr_done && aligned && idx == pnd_pkg::IDX_ENA_HI)
      begin
        output_enable_hi_pair_ff <= wbyte;
      end
      else if (wr_done && aligned && idx == pnd_pkg::IDX_TRIG_SEL)
      begin
        trigger_select_reg_ff <= wbyte; // see [RULE_20]
      end
    end
  end

  // direction bits are software's job to set for pattern pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_b_dir_ff <= pnd_pkg::RST_BYTE; // see [RULE_01]
    end
    else if (clk_en)
    begin
      if (wr_done && aligned && idx == pnd_pkg::IDX_PORT_B_DIR)
      begin
        port_b_dir_ff <= wbyte; // see [RULE_01] see [RULE_02]
      end
    end
  end

  // ****************************************************************
  // port data: transfer wins on enabled bits, writes land on the rest
  // ****************************************************************
  always_comb
  begin
    nxt_port_a = port_a_data_ff;
    nxt_port_b = port_b_data_ff;
    if (wr_done && aligned && idx == pnd_pkg::IDX_PORT_A_DATA)
    begin
      nxt_port_a = (port_a_data_ff & output_enable_lo_pair_ff) |
                   (wbyte & ~output_enable_lo_pair_ff); // see [RULE_19]
    end
    if (wr_done && aligned && idx == pnd_pkg::IDX_PORT_B_DATA)
    begin
      nxt_port_b = (port_b_data_ff & output_enable_hi_pair_ff) |
                   (wbyte & ~output_enable_hi_pair_ff); // see [RULE_04]
    end
    nxt_port_a = (nxt_port_a & ~xfer[7:0]) |
                 (next_data_lo_pair_ff & xfer[7:0]); // see [RULE_05] see [RULE_17]
    nxt_port_b = (nxt_port_b & ~xfer[15:8]) |
                 (next_data_hi_pair_ff & xfer[15:8]); // see [RULE_12] see [RULE_17]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_a_data_ff <= pnd_pkg::RST_BYTE;
      port_b_data_ff <= pnd_pkg::RST_BYTE; // see [RULE_03]
    end
    else if (clk_en)
    begin
      port_a_data_ff <= nxt_port_a; // see [RULE_21]
      port_b_data_ff <= nxt_port_b; // see [RULE_03] see [RULE_21]
    end
  end

endmodule : pnd_regs

// [verif/pnd_regs_properties.sv]
// assertions on the apb answer and the port registers of pnd_regs
// assumes one clock domain; clk_en gates every register update
`timescale 1ns/1ps

module pnd_regs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [21:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] compare_match,
  input wire logic [7:0] port_a_output_data,
  input wire logic [7:0] port_b_output_data,
  input wire logic [7:0] port_b_direction
);
  // ********
  // helpers
  // ********
  localparam logic [21:0] A_DIR = {pnd_pkg::IDX_PORT_B_DIR, 2'b00};
  localparam logic [21:0] A_PA = {pnd_pkg::IDX_PORT_A_DATA, 2'b00};
  localparam logic [21:0] A_PB = {pnd_pkg::IDX_PORT_B_DATA, 2'b00};
  localparam logic [21:0] A_G0 = {pnd_pkg::IDX_ND_G0_ALT, 2'b00};
  localparam logic [21:0] A_G2 = {pnd_pkg::IDX_ND_G2_ALT, 2'b00};
  logic wr_go;
  logic rd_go;
  assign wr_go = psel && penable && pready && pwrite && clk_en;
  assign rd_go = pready && !pwrite && !pslverr;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_one_wait: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("no answer one cycle after the access cycle");
  a_ready_single: assert property (pready && clk_en |=> !pready)
    else $error("answer stands longer than one cycle");
  a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_dir_reads_zero: assert property (rd_go && paddr == A_DIR |-> prdata == 32'h0)
    else $error("direction register readable");
  a_dir_cause: assert property (
    $changed(port_b_direction) |-> $past(wr_go && paddr == A_DIR))
    else $error("direction changed without a write");
  a_pb_cause: assert property ($changed(port_b_output_data) |->
    $past(clk_en && (compare_match != 3'h0 || (wr_go && paddr == A_PB))))
    else $error("port b data changed without write or match");
  a_pa_cause: assert property ($changed(port_a_output_data) |->
    $past(clk_en && (compare_match != 3'h0 || (wr_go && paddr == A_PA))))
    else $error("port a data changed without write or match");
  a_alt_hi_ones: assert property (
    rd_go && (paddr == A_G0 || paddr == A_G2) |-> prdata == {24'h0, 4'hf, prdata[3:0]})
    else $error("alternate address upper nibble not ones");
endmodule : pnd_regs_properties

// [verif/pnd_match_src.sv]
// compare-match event source standing in for the three timer channels
// assumes pulse is called right after a rising edge of pclk
`timescale 1ns/1ps

module pnd_match_src (
  input wire logic pclk,
  output logic [2:0] compare_match
);
  initial compare_match = 3'h0;
  // one-cycle pulse on the masked channels, then gap idle cycles (slow timer)
  task automatic pulse(input logic [2:0] mask, input int gap);
    compare_match <= mask;
    @(posedge pclk);
    compare_match <= 3'h0;
    repeat (gap) @(posedge pclk);
  endtask : pulse
endmodule : pnd_match_src

// [verif/tb_pattern_next_data_regs.sv]
// self-checking bench for pnd_regs: apb master, reference model, random traffic
// assumes pnd_pkg, pnd_match_src and the checker are compiled first
`timescale 1ns/1ps

module tb_pattern_next_data_regs;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic hw_standby = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [21:0] paddr = 22'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] compare_match;
  logic [7:0] port_a_output_data;
  logic [7:0] port_b_output_data;
  logic [7:0] port_b_direction;
  logic [31:0] seed = 32'hbbafef5d;
  logic [7:0] trig, ena_lo, ena_hi, nd_lo, nd_hi, pa, pb, dir;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int check_count = 0;
  logic [19:0] regs [10] = '{pnd_pkg::IDX_PORT_B_DIR, pnd_pkg::IDX_PORT_A_DATA,
    pnd_pkg::IDX_PORT_B_DATA, pnd_pkg::IDX_TRIG_SEL, pnd_pkg::IDX_ENA_HI, pnd_pkg::IDX_ENA_LO,
    pnd_pkg::IDX_ND_HI, pnd_pkg::IDX_ND_LO, pnd_pkg::IDX_ND_G2_ALT, pnd_pkg::IDX_ND_G0_ALT};

  always #20 pclk = ~pclk;

  pnd_regs dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .hw_standby(hw_standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_match(compare_match),
    .port_a_output_data(port_a_output_data), .port_b_output_data(port_b_output_data),
    .port_b_direction(port_b_direction));
  pnd_match_src src_u (.pclk(pclk), .compare_match(compare_match));

  // ********
  // reference model
  // ********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [1:0] chan(input logic [1:0] f);
    return f[1] ? 2'h2 : f;
  endfunction : chan
  // 10 and 11 both pick channel 2, so they count as one trigger
  function automatic logic same(input logic hi);
    return hi ? chan(trig[7:6]) == chan(trig[5:4]) : chan(trig[3:2]) == chan(trig[1:0]);
  endfunction : same
  function automatic logic [7:0] nd_mask(input logic shared, input logic alt);
    if (shared)
      return alt ? 8'h00 : 8'hff;
    return alt ? 8'h0f : 8'hf0;
  endfunction : nd_mask
  function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] v,
    input logic [7:0] m);
    return (o & ~m) | (v & m);
  endfunction : merge
  function automatic logic [7:0] exp_read(input int k);
    case (k)
      1: return pa;
      2: return pb;
      3: return trig;
      4: return ena_hi;
      5: return ena_lo;
      6, 8: return (nd_hi & nd_mask(same(1'b1), k == 8)) | ~nd_mask(same(1'b1), k == 8);
      7, 9: return (nd_lo & nd_mask(same(1'b0), k == 9)) | ~nd_mask(same(1'b0), k == 9);
      default: return 8'h00;
    endcase
  endfunction : exp_read

  // ********
  // bus and compare tasks
  // ********
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [19:0] idx, input logic [7:0] v);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 50)
    begin
      miscompares++;
      print_verdict();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic wr(input int k, input logic [7:0] v);
    apb(1'b1, regs[k], v);
    case (k)
      0: dir = v;
      1: pa = merge(pa, v, ~ena_lo);
      2: pb = merge(pb, v, ~ena_hi);
      3: trig = v;
      4: ena_hi = v;
      5: ena_lo = v;
      6, 8: nd_hi = merge(nd_hi, v, nd_mask(same(1'b1), k == 8));
      default: nd_lo = merge(nd_lo, v, nd_mask(same(1'b0), k == 9));
    endcase
  endtask : wr
  task automatic rchk(input int k);
    apb(1'b0, regs[k], 8'h00);
    chk("read", 32'(exp_read(k)), rd);
    chk("read_err", 32'h0, 32'(err));
  endtask : rchk
  task automatic chk_ports();
    @(negedge pclk);
    chk("port_a", 32'(pa), 32'(port_a_output_data));
    chk("port_b", 32'(pb), 32'(port_b_output_data));
    chk("port_b_dir", 32'(dir), 32'(port_b_direction));
  endtask : chk_ports
  // transfer of enabled next-data bits of every group whose channel fired
  task automatic xfer(input logic [2:0] m);
    logic [15:0] po, en, nd;
    po = {pb, pa};
    en = {ena_hi, ena_lo};
    nd = {nd_hi, nd_lo};
    @(posedge pclk);
    src_u.pulse(m, 0);
    for (int b = 0; b < 16; b++)
      if (m[chan(trig[2*(b/4)+:2])] && en[b])
        po[b] = nd[b];
    {pb, pa} = po;
  endtask : xfer

  initial
  begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    {pa, pb, dir, ena_lo, ena_hi, nd_lo, nd_hi} = 56'h0;
    trig = 8'hff;
    for (int k = 0; k < 10; k++)
      rchk(k);
    chk_ports();
    wr(0, 8'hff);
    chk_ports();
    $display("test reset done");
    for (int it = 0; it < 24; it++)
    begin
      wr(3, it == 0 ? 8'h00 : it == 1 ? 8'he4 : it == 2 ? 8'h1b : 8'(rnd()));
      for (int k = 1; k < 10; k++)
        if (k != 3)
          wr(k, 8'(rnd()));
      for (int k = 0; k < 10; k++)
        if (k == 7 || k == 9)
          rchk(k);
        else
          rchk(k);
      chk_ports();
      xfer(3'(rnd()));
      chk_ports();
    end
    $display("test random traffic done");
    // a frozen clock enable must drop the match pulses
    @(posedge pclk);
    clk_en <= 1'b0;
    src_u.pulse(3'h7, 1);
    clk_en <= 1'b1;
    chk_ports();
    apb(1'b1, 20'h00001, 8'h5a);
    apb(1'b0, 20'h00001, 8'h00);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_data", 32'h0, rd);
    $display("test refusal done");
    @(posedge pclk);
    hw_standby <= 1'b1;
    repeat (5) @(posedge pclk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge pclk);
    {nd_lo, nd_hi, ena_lo, ena_hi} = 32'h0;
    trig = 8'hff;
    for (int k = 0; k < 10; k++)
      rchk(k);
    chk_ports();
    $display("test standby done");
    print_verdict();
  end
endmodule : tb_pattern_next_data_regs

bind pnd_regs pnd_regs_properties props_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .compare_match(compare_match),
  .port_a_output_data(port_a_output_data), .port_b_output_data(port_b_output_data),
  .port_b_direction(port_b_direction));
